//--- hdl/charger_option_low_byte.sv
`timescale 1ns/1ps
`default_nettype none
module charger_option_low_byte
  import cob_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register access from the management bus engine
  input wire logic regWrite,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  // Analog comparator levels, asynchronous
  input wire logic adapterDetectAbove,
  input wire logic batteryDepleted,
  input wire logic boostActiveIn,
  // Power stage controls
  output logic adapterPathSwitchOn,
  output logic batteryPathSwitchOn,
  output logic lowSideFaultThresholdSel,
  output logic boostCurrentLimitSel,
  output logic currentMonitorOutputSel,
  output logic boostEnable,
  output logic inputOvercurrentProtect,
  output logic chargeInhibit,
  output logic [1:0] depletionThresholdSel,
  output logic learnActive
);
  // ==========================================================
  // Synchronised status inputs
  logic [2:0] rawIn;
  logic [2:0] syncIn;
  logic adapterPresent;
  logic depleted;
  logic boostActive;
  assign rawIn = {adapterDetectAbove, batteryDepleted, boostActiveIn};
  cob_sync2 #(.W(3)) uSync (
    .refClk(ref_clk),
    .nrst(nrst),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );
  assign adapterPresent = syncIn[2];
  assign depleted = syncIn[1];
  assign boostActive = syncIn[0];

  // ==========================================================
  // Writable control bits
  logic lowFault_reg;
  logic monSel_reg;
  logic boostEn_reg;
  logic overcur_reg;
  logic inhibit_reg;
  logic [1:0] depl_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lowFault_reg <= CTRL_RESET[BIT_LOWFAULT];
      monSel_reg <= CTRL_RESET[BIT_MONSEL];
      boostEn_reg <= CTRL_RESET[BIT_BOOSTEN];
      overcur_reg <= CTRL_RESET[BIT_OVERCUR];
      inhibit_reg <= CTRL_RESET[BIT_INHIBIT];
      depl_reg <= DEPL_RESET;
    end else if (regWrite) begin
      lowFault_reg <= regWdata[BIT_LOWFAULT];
      monSel_reg <= regWdata[BIT_MONSEL];
      boostEn_reg <= regWdata[BIT_BOOSTEN];
      overcur_reg <= regWdata[BIT_OVERCUR];
      inhibit_reg <= regWdata[BIT_INHIBIT];
      depl_reg <= regWdata[DEPL_LSB +: DEPL_W];
    end
  end

  // ==========================================================
  // Learn sequencer
  // A host write of 1 while depleted still starts; the comparator ends it next cycle.
  cob_learn_e state_reg;
  cob_learn_e state_next;
  logic learnStart;
  logic learnAbort;
  assign learnStart = regWrite && regWdata[BIT_LEARN];
  assign learnAbort = regWrite && !regWdata[BIT_LEARN];
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      COB_IDLE: begin
        if (learnStart) begin
          state_next = COB_LEARN;
        end
      end
      COB_LEARN: begin
        if (learnAbort) begin
          state_next = COB_IDLE;
        end else if (depleted && !learnStart) begin
          // Host rewrite of 1 wins over the self-clear for this cycle
          state_next = COB_DONE;
        end
      end
      COB_DONE: begin
        // Restart by host wins over the self-clear
        if (learnStart) begin
          state_next = COB_LEARN;
        end else begin
          state_next = COB_IDLE;
        end
      end
      default: begin
        state_next = COB_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= COB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  logic learnNext;
  logic [15:0] readWord;
  assign learnNext = (state_next == COB_LEARN);

  // ==========================================================
  // Registered outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      adapterPathSwitchOn <= 1'b1;
      batteryPathSwitchOn <= 1'b0;
      learnActive <= 1'b0;
      lowSideFaultThresholdSel <= CTRL_RESET[BIT_LOWFAULT];
      boostCurrentLimitSel <= CTRL_RESET[BIT_LOWFAULT];
      currentMonitorOutputSel <= CTRL_RESET[BIT_MONSEL];
      boostEnable <= CTRL_RESET[BIT_BOOSTEN];
      inputOvercurrentProtect <= CTRL_RESET[BIT_OVERCUR];
      chargeInhibit <= CTRL_RESET[BIT_INHIBIT];
      depletionThresholdSel <= DEPL_RESET;
      regRdata <= '0;
    end else begin
      adapterPathSwitchOn <= !learnNext;
      batteryPathSwitchOn <= learnNext;
      learnActive <= learnNext;
      lowSideFaultThresholdSel <= lowFault_reg;
      boostCurrentLimitSel <= boostActive && lowFault_reg;
      currentMonitorOutputSel <= monSel_reg;
      boostEnable <= boostEn_reg;
      inputOvercurrentProtect <= overcur_reg;
      chargeInhibit <= inhibit_reg;
      depletionThresholdSel <= depl_reg;
      regRdata <= readWord;
    end
  end

  // ==========================================================
  // Read word, status bits live and never written
  always_comb begin
    readWord = '0;
    readWord[DEPL_LSB +: DEPL_W] = depl_reg;
    readWord[BIT_LOWFAULT] = lowFault_reg;
    readWord[BIT_LEARN] = (state_reg == COB_LEARN);
    readWord[BIT_MONSEL] = monSel_reg;
    readWord[BIT_ADAPTER] = adapterPresent;
    readWord[BIT_BOOSTEN] = boostEn_reg;
    readWord[BIT_BOOSTACT] = boostActive;
    readWord[BIT_OVERCUR] = overcur_reg;
    readWord[BIT_INHIBIT] = inhibit_reg;
  end
endmodule
`default_nettype wire

//--- hdl/cob_pkg.sv
`default_nettype none
package cob_pkg;
  // ==========================================================
  // Register layout
  localparam int REG_WIDTH = 16;
  localparam int BIT_LOWFAULT = 7;
  localparam int BIT_LEARN = 6;
  localparam int BIT_MONSEL = 5;
  localparam int BIT_ADAPTER = 4;
  localparam int BIT_BOOSTEN = 3;
  localparam int BIT_BOOSTACT = 2;
  localparam int BIT_OVERCUR = 1;
  localparam int BIT_INHIBIT = 0;
  localparam int DEPL_LSB = 11;
  localparam int DEPL_W = 2;
  // ==========================================================
  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h1802;
  localparam logic [1:0] DEPL_RESET = 2'h3;
  // ==========================================================
  // Learn sequencer
  typedef enum logic [1:0] {
    COB_IDLE = 2'b00,
    COB_LEARN = 2'b01,
    COB_DONE = 2'b10
  } cob_learn_e;
endpackage
`default_nettype wire

//--- hdl/cob_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module cob_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic refClk,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_reg;
  // ==========================================================
  // Two flops, first read only by second
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= '0;
      syncOut <= '0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

//--- testbench/charger_option_low_byte_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port-level checks, write to control outputs is two edges, to learn outputs one edge
module cob_checker (
  input wire logic ref_clk, nrst, regWrite, adapterDetectAbove, batteryDepleted, boostActiveIn,
  input wire logic [15:0] regWdata, regRdata,
  input wire logic adapterPathSwitchOn, batteryPathSwitchOn, lowSideFaultThresholdSel,
  input wire logic boostCurrentLimitSel, currentMonitorOutputSel, boostEnable,
  input wire logic inputOvercurrentProtect, chargeInhibit, learnActive,
  input wire logic [1:0] depletionThresholdSel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  low_fault_a: assert property (
    regWrite |-> ##2 lowSideFaultThresholdSel == $past(regWdata[7], 2)) else $error("low fault");
  ctrl_bits_a: assert property (
    regWrite |-> ##2 {currentMonitorOutputSel, boostEnable, inputOvercurrentProtect,
      chargeInhibit} == $past({regWdata[5], regWdata[3], regWdata[1:0]}, 2)) else $error("ctrl");
  depl_sel_a: assert property (
    regWrite |-> ##2 depletionThresholdSel == $past(regWdata[12:11], 2)) else $error("depl");
  learn_start_a: assert property (
    regWrite && regWdata[6] |=> batteryPathSwitchOn && !adapterPathSwitchOn && learnActive)
    else $error("learn start");
  learn_abort_a: assert property (
    regWrite && !regWdata[6] |=> adapterPathSwitchOn && !batteryPathSwitchOn)
    else $error("learn abort");
  learn_end_a: assert property (
    (learnActive && batteryDepleted) ##1 batteryDepleted[*2] |-> ##[0:2] !learnActive
    ##[1:3] !regRdata[6]) else $error("learn end");
  adapter_ro_a: assert property (
    $stable(adapterDetectAbove)[*5] |-> regRdata[4] == adapterDetectAbove) else $error("adapter");
  boost_limit_a: assert property (
    boostActiveIn[*5] |-> boostCurrentLimitSel == lowSideFaultThresholdSel) else $error("limit");
  boost_off_a: assert property (
    (!boostActiveIn)[*5] |-> !boostCurrentLimitSel) else $error("limit off");
  cover property (learnActive ##1 !learnActive);
  cover property (regWrite && !regWdata[6] && learnActive);
  cover property (boostCurrentLimitSel);
endmodule
bind charger_option_low_byte cob_checker u_cob_checker (.*);
`default_nettype wire

//--- testbench/cob_plant_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Power stage stand-in; slow drain lets a learn be aborted
module cob_plant_model (
  input wire logic ref_clk, batOn, boostOn, slow, acIn,
  output logic adapterDetectAbove = 1'b0,
  output logic batteryDepleted = 1'b0,
  output logic boostActiveIn = 1'b0
);
  int drain = 0;
  always @(posedge ref_clk) begin
    drain <= batOn ? drain + 1 : 0;
    batteryDepleted <= batOn && drain > (slow ? 40 : 6);
    boostActiveIn <= boostOn;
    adapterDetectAbove <= acIn;
  end
endmodule
`default_nettype wire

//--- testbench/charger_option_low_byte_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module charger_option_low_byte_tb;
  logic ref_clk = 0, nrst = 0, regWrite = 0, slow = 0, acIn = 0;
  logic [15:0] regWdata = 16'h0, regRdata;
  logic adapterDetectAbove, batteryDepleted, boostActiveIn, apOn, bpOn, lsSel, blSel;
  logic monSel, bEn, ocp, inh, learnActive;
  logic [1:0] depl;
  int error_cnt = 0, checks_done = 0;
  initial forever #2.5 ref_clk = ~ref_clk;
  charger_option_low_byte u_charger_option_low_byte (.ref_clk, .nrst, .regWrite, .regWdata,
    .regRdata, .adapterDetectAbove, .batteryDepleted, .boostActiveIn, .adapterPathSwitchOn(apOn),
    .batteryPathSwitchOn(bpOn), .lowSideFaultThresholdSel(lsSel), .boostCurrentLimitSel(blSel),
    .currentMonitorOutputSel(monSel), .boostEnable(bEn), .inputOvercurrentProtect(ocp),
    .chargeInhibit(inh), .depletionThresholdSel(depl), .learnActive);
  cob_plant_model u_cob_plant_model (.ref_clk, .batOn(bpOn), .boostOn(bEn), .slow, .acIn,
    .adapterDetectAbove, .batteryDepleted, .boostActiveIn);
  // ==========
  // Bus tasks
  task automatic wr(input logic [15:0] d);
    @(posedge ref_clk) begin regWrite <= 1'b1; regWdata <= d; end
    @(posedge ref_clk) regWrite <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin #20000; error_cnt++; final_report(); end
  // ==========
  // Tests
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    wt(4);
    `CHK("reset rd", 16'h1802, regRdata)
    `CHK("reset out", 7'h42, {apOn, bpOn, lsSel, monSel, bEn, ocp, inh})
    $display("test reset done");
    wr(16'he8bd);
    wt(8);
    `CHK("ctrl rd", 16'h08ad, regRdata)
    `CHK("ctrl out", 8'hf5, {lsSel, blSel, monSel, bEn, ocp, inh, depl})
    wr(16'h0002);
    wt(8);
    `CHK("clr rd", 16'h0002, regRdata)
    `CHK("clr out", 8'h08, {lsSel, blSel, monSel, bEn, ocp, inh, depl})
    for (int i = 0; i < 4; i++) begin
      wr({3'h0, i[1:0], 3'h0, 8'h80});
      wt(2);
      `CHK("depl", i[1:0], depl)
      `CHK("limit off", 2'b10, {lsSel, blSel})
    end
    @(posedge ref_clk) acIn <= 1'b1;
    wt(8);
    `CHK("adapter", 1'b1, regRdata[4])
    $display("test fields done");
    wr(16'h1840);
    #1;
    `CHK("learn on", 3'b011, {apOn, bpOn, learnActive})
    for (int k = 0; k < 100 && learnActive === 1'b1; k++) wt(1);
    `CHK("learn end", 2'b10, {apOn, bpOn})
    wt(4);
    `CHK("learn bit", 1'b0, regRdata[6])
    $display("test learn done");
    slow <= 1'b1;
    wr(16'h1840);
    wt(3);
    `CHK("learn rd", 1'b1, regRdata[6])
    `CHK("status ro", 2'b10, {regRdata[4], regRdata[2]})
    wr(16'h1800);
    #1;
    `CHK("abort", 3'b100, {apOn, bpOn, learnActive})
    $display("test abort done");
    final_report();
  end
endmodule
`default_nettype wire
